// ==== hdl/rtc_cfg.svh ====
/*
 * constants of the real-time clock block: register offsets, field positions,
 * reset values and timing figures.
 * assumes inclusion by its bare name from the design and bench modules.
 */
// Operation
// - timebase is the slow crystal input
// - prescaler turns crystal into one-second tick
// - seconds and minutes count modulo sixty
// - hours modulo twenty-four, days span 32768
// - periodic events on second, minute, hour, day
// - enabled alarm fires when time equals setting
// - first alarm compares time of day only
// - second alarm compares day and time
// - stopwatch loads value, counts down each second
// - enabled stopwatch underflow raises an event
// - counting continues while processor sleeps
// - enabled event wakes processor from sleep
// - wake also leaves deep sleep and hibernate
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RTC_CLK_HZ 25000000
`define RTC_XTAL_HZ 32768
`define RTC_TICK_HZ 1
`define RTC_PRESCALE_DIV (`RTC_XTAL_HZ / `RTC_TICK_HZ)
`define RTC_SEC_MOD 60
`define RTC_MIN_MOD 60
`define RTC_HOUR_MOD 24
`define RTC_DAY_MOD 32768

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define RTC_OFS_CTRL 8'h00
`define RTC_OFS_TIME 8'h04
`define RTC_OFS_DAY 8'h08
`define RTC_OFS_ALM1 8'h0C
`define RTC_OFS_ALM2 8'h10
`define RTC_OFS_ALM2_DAY 8'h14
`define RTC_OFS_SWATCH 8'h18
`define RTC_OFS_STATUS 8'h1C
`define RTC_OFS_CLEAR 8'h20
`define RTC_OFS_IEN 8'h24
`define RTC_OFS_WEN 8'h28

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define RTC_CTRL_ALM1_EN 0
`define RTC_CTRL_ALM2_EN 1
`define RTC_CTRL_SW_EN 2
`define RTC_SEC_LSB 0
`define RTC_MIN_LSB 8
`define RTC_HOUR_LSB 16
`define RTC_CTRL_RESET 3'h0
`define RTC_EVT_RESET 7'h00

`endif

// ==== hdl/rtc_pkg.sv ====
/*
 * types of the real-time clock block.
 * assumes rtc_cfg.svh is on the include path.
 */
package rtc_pkg;
    // ------------------------------------------------------------------------
    // event bit positions in status, clear, enable and wake registers
    // ------------------------------------------------------------------------
    typedef enum {
        EV_SEC, EV_MIN, EV_HOUR, EV_DAY, EV_ALM1, EV_ALM2, EV_SWATCH, EV_COUNT
    } event_type;

    typedef logic [EV_COUNT-1:0] event_vec_type;

    // time of day as held by counters and alarms
    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } tod_type;
endpackage

// ==== hdl/rtc_cnt_if.sv ====
/*
 * carrier between the top module and one modulo counter.
 * assumes both ends share the clock of the top module.
 */
`timescale 1ns/1ns
interface rtc_cnt_if #(parameter int W = 6);
    logic inc;
    logic load;
    logic [W-1:0] load_val;
    logic [W-1:0] value;
    logic wrap;

    modport counter(input inc, load, load_val, output value, wrap);
    modport user(output inc, load, load_val, input value, wrap);
endinterface

// ==== hdl/rtc_mod_counter.sv ====
/*
 * one modulo counter with load, used for seconds, minutes, hours and days.
 * assumes the system clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module rtc_mod_counter #(
    parameter int W = 6,
    parameter int MOD = 60
) (
    input wire logic clk_i,
    input wire logic rst_i,
    rtc_cnt_if.counter c
);
    typedef struct packed {
        logic [W-1:0] value;
    } cnt_state_type;

    localparam logic [W-1:0] MAX = W'(MOD - 1);

    cnt_state_type q;
    cnt_state_type d;

    // ------------------------------------------------------------------------
    // next value: a load from software wins over a step
    // ------------------------------------------------------------------------
    always_comb begin
        d = q;
        if (c.load) begin
            d.value = c.load_val;
        end else if (c.inc) begin
            d.value = (q.value == MAX) ? '0 : q.value + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // carry to the next counter in the same cycle as the step
    assign c.value = q.value;
    assign c.wrap = c.inc & ~c.load & (q.value == MAX);

    a_wrap_to_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        c.wrap |=> (q.value == '0)) else $error("counter did not wrap to zero");
endmodule

// ==== hdl/rtc_top.sv ====
/*
 * real-time clock: crystal prescaler, time-of-day and day counters, two
 * alarms, a down-counting stopwatch, sticky events with irq and wake outputs,
 * registers on a classic wishbone slave.
 * assumes the crystal clock arrives as a plain input far slower than clk_i,
 * and that clk_i keeps running while the processor sleeps.
 */
`timescale 1ns/1ns
`include "rtc_cfg.svh"
module rtc_top
    import rtc_pkg::*;
#(
    parameter int PRESCALE_DIV = `RTC_PRESCALE_DIV,
    parameter int SW_W = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic xtal_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic wake_o
);
    localparam int PRE_W = (PRESCALE_DIV > 1) ? $clog2(PRESCALE_DIV) : 1;
    localparam logic [PRE_W-1:0] PRE_MAX = PRE_W'(PRESCALE_DIV - 1);

    typedef struct packed {
        logic xs1;
        logic xs2;
        logic xs3;
        logic [PRE_W-1:0] pre;
        logic tick;
        logic cmp;
        logic [2:0] ctrl;
        event_vec_type ien;
        event_vec_type wen;
        event_vec_type status;
        tod_type alm1;
        tod_type alm2;
        logic [14:0] alm2_day;
        logic [SW_W-1:0] sw;
        logic sw_run;
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic wake;
    } top_state_type;

    top_state_type q;
    top_state_type d;

    rtc_cnt_if #(.W(6)) sec_if();
    rtc_cnt_if #(.W(6)) min_if();
    rtc_cnt_if #(.W(5)) hour_if();
    rtc_cnt_if #(.W(15)) day_if();

    // ------------------------------------------------------------------------
    // timekeeping counters
    // ------------------------------------------------------------------------
    rtc_mod_counter #(.W(6), .MOD(`RTC_SEC_MOD)) u_sec (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .c(sec_if)
    );
    rtc_mod_counter #(.W(6), .MOD(`RTC_MIN_MOD)) u_min (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .c(min_if)
    );
    rtc_mod_counter #(.W(5), .MOD(`RTC_HOUR_MOD)) u_hour (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .c(hour_if)
    );
    rtc_mod_counter #(.W(15), .MOD(`RTC_DAY_MOD)) u_day (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .c(day_if)
    );

    logic req;
    logic wr;
    logic [31:0] mask;
    logic [31:0] rd;
    logic [31:0] wval;
    tod_type now;
    tod_type tval;
    event_vec_type evt;

    assign req = wb_cyc_i & wb_stb_i & ~q.ack;
    // a write lands on the edge that shows ack, while the master still holds it
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;
    assign mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign now = '{hour: hour_if.value, min: min_if.value, sec: sec_if.value};
    assign wval = (rd & ~mask) | (wb_dat_i & mask);
    assign tval = '{hour: wval[`RTC_HOUR_LSB +: 5], min: wval[`RTC_MIN_LSB +: 6],
                    sec: wval[`RTC_SEC_LSB +: 6]};

    // counter chain: each stage steps on the carry of the one below
    assign sec_if.inc = q.tick;
    assign min_if.inc = sec_if.wrap;
    assign hour_if.inc = min_if.wrap;
    assign day_if.inc = hour_if.wrap;
    assign sec_if.load = wr & (wb_adr_i == `RTC_OFS_TIME);
    assign min_if.load = sec_if.load;
    assign hour_if.load = sec_if.load;
    assign day_if.load = wr & (wb_adr_i == `RTC_OFS_DAY);
    assign sec_if.load_val = tval.sec;
    assign min_if.load_val = tval.min;
    assign hour_if.load_val = tval.hour;
    assign day_if.load_val = wval[14:0];

    // ------------------------------------------------------------------------
    // register read mux, unmapped offsets read as zero
    // ------------------------------------------------------------------------
    always_comb begin
        rd = 32'h0000_0000;
        unique case (wb_adr_i)
            `RTC_OFS_CTRL: rd = {29'h0000_0000, q.ctrl};
            `RTC_OFS_TIME: rd = {11'h000, now.hour, 2'h0, now.min, 2'h0, now.sec};
            `RTC_OFS_DAY: rd = {17'h0_0000, day_if.value};
            `RTC_OFS_ALM1: rd = {11'h000, q.alm1.hour, 2'h0, q.alm1.min, 2'h0, q.alm1.sec};
            `RTC_OFS_ALM2: rd = {11'h000, q.alm2.hour, 2'h0, q.alm2.min, 2'h0, q.alm2.sec};
            `RTC_OFS_ALM2_DAY: rd = {17'h0_0000, q.alm2_day};
            `RTC_OFS_SWATCH: rd = 32'(q.sw);
            `RTC_OFS_STATUS: rd = {25'h000_0000, q.status};
            `RTC_OFS_IEN: rd = {25'h000_0000, q.ien};
            `RTC_OFS_WEN: rd = {25'h000_0000, q.wen};
            default: rd = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------------
    // events of this cycle
    // ------------------------------------------------------------------------
    always_comb begin
        evt = '0;
        evt[EV_SEC] = q.tick;
        evt[EV_MIN] = sec_if.wrap;
        evt[EV_HOUR] = min_if.wrap;
        evt[EV_DAY] = hour_if.wrap;
        // compared one cycle after the tick, once counters have settled
        evt[EV_ALM1] = q.cmp & q.ctrl[`RTC_CTRL_ALM1_EN] & (now == q.alm1);
        evt[EV_ALM2] = q.cmp & q.ctrl[`RTC_CTRL_ALM2_EN] & (now == q.alm2)
                       & (day_if.value == q.alm2_day);
        evt[EV_SWATCH] = q.tick & q.sw_run & q.ctrl[`RTC_CTRL_SW_EN]
                         & (q.sw == '0);
    end

    // ------------------------------------------------------------------------
    // next state of the whole block
    // ------------------------------------------------------------------------
    always_comb begin
        d = q;
        // crystal passes two flops before the edge detector looks at it
        d.xs1 = xtal_i;
        d.xs2 = q.xs1;
        d.xs3 = q.xs2;
        d.tick = 1'b0;
        if (q.xs2 & ~q.xs3) begin
            if (q.pre == PRE_MAX) begin
                d.pre = '0;
                d.tick = 1'b1;
            end else begin
                d.pre = q.pre + PRE_W'(1);
            end
        end
        d.cmp = q.tick;
        // stopwatch: stops itself after underflow rather than wrapping
        if (q.tick & q.sw_run & q.ctrl[`RTC_CTRL_SW_EN]) begin
            if (q.sw == '0) begin
                d.sw_run = 1'b0;
            end else begin
                d.sw = q.sw - SW_W'(1);
            end
        end
        // bus: one access per request, acknowledged the next cycle
        d.ack = req;
        d.dat = 32'h0000_0000;
        if (req & ~wb_we_i) begin
            d.dat = rd;
        end
        d.status = q.status;
        if (wr) begin
            unique case (wb_adr_i)
                `RTC_OFS_CTRL: d.ctrl = wval[2:0];
                `RTC_OFS_ALM1: d.alm1 = tval;
                `RTC_OFS_ALM2: d.alm2 = tval;
                `RTC_OFS_ALM2_DAY: d.alm2_day = wval[14:0];
                `RTC_OFS_SWATCH: begin
                    d.sw = wval[SW_W-1:0];
                    d.sw_run = 1'b1;
                end
                `RTC_OFS_CLEAR: d.status = q.status & ~(wb_dat_i[6:0] & mask[6:0]);
                `RTC_OFS_IEN: d.ien = wval[6:0];
                `RTC_OFS_WEN: d.wen = wval[6:0];
                default: d.status = q.status;
            endcase
        end
        // a new event beats a clear in the same cycle
        d.status = d.status | evt;
        // runs from clk_i alone, so the sleep state of the core does not stop it
        d.irq = |(q.status & q.ien);
        // one wake line serves sleep, deep sleep and regulator hibernate exit
        d.wake = |(q.status & q.wen);
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.ctrl <= `RTC_CTRL_RESET;
            q.status <= `RTC_EVT_RESET;
            q.ien <= `RTC_EVT_RESET;
            q.wen <= `RTC_EVT_RESET;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign irq_o = q.irq;
    assign wake_o = q.wake;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_sw_load;
        wr && (wb_adr_i == `RTC_OFS_SWATCH);
    endsequence

    sequence s_sw_step;
        q.tick && q.sw_run && q.ctrl[`RTC_CTRL_SW_EN] && (q.sw != '0) && !wr;
    endsequence

    // bus: one ack per request, and never an ack that nobody asked for
    a_bus_ack_pulse: assert property (
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle pulse");
    a_bus_ack_cause: assert property (
        wb_ack_o |-> $past(req))
        else $error("ack without a request");

    // timebase and counter chain
    a_tick_prescale: assert property (
        q.tick |-> $past(q.pre) == PRE_MAX)
        else $error("tick without full prescale count");
    a_sec_wrap: assert property (
        q.tick && sec_if.value == 6'h3B && !wr
        |=> sec_if.value == 6'h00 && evt[EV_SEC] == 1'b0)
        else $error("seconds failed to wrap");
    a_hour_wrap: assert property (
        min_if.wrap && hour_if.value == 5'h17 && !wr
        |=> hour_if.value == 5'h00 && day_if.value == $past(day_if.value) + 15'h0001)
        else $error("hour wrap did not advance day");
    a_min_carry: assert property (
        sec_if.wrap && min_if.value != 6'h3B && !wr
        |=> min_if.value == $past(min_if.value) + 6'h01)
        else $error("minute missed carry");

    // alarms
    a_alarm_one: assert property (
        q.cmp && q.ctrl[`RTC_CTRL_ALM1_EN] && now == q.alm1
        |=> q.status[EV_ALM1])
        else $error("first alarm not flagged");
    a_alarm_two: assert property (
        q.cmp && q.ctrl[`RTC_CTRL_ALM2_EN] && now == q.alm2
        && day_if.value != q.alm2_day && !q.status[EV_ALM2]
        |=> !q.status[EV_ALM2])
        else $error("second alarm ignored day");

    // stopwatch; a clear written right after underflow may drop the flag
    a_sw_count: assert property (
        s_sw_step |=> q.sw == $past(q.sw) - SW_W'(1))
        else $error("stopwatch did not step down");
    a_sw_under: assert property (
        q.tick && q.sw_run && q.ctrl[`RTC_CTRL_SW_EN] && q.sw == '0 && !wr
        |=> q.status[EV_SWATCH] && !q.sw_run ##1 (q.status[EV_SWATCH] || $past(wr)))
        else $error("stopwatch underflow not flagged");
    a_sw_reload: assert property (s_sw_load |=> q.sw_run) else $error("stopwatch not armed");

    // sticky flags, irq and wake are registered levels of the masked flags
    a_set_beats_clr: assert property (
        evt[EV_SEC] |=> q.status[EV_SEC])
        else $error("event lost against clear");
    a_irq_level: assert property (
        (|(q.status & q.ien)) |=> irq_o)
        else $error("irq not raised");
    a_irq_quiet: assert property (
        ((q.status & q.ien) == '0) |=> !irq_o)
        else $error("irq without enabled event");
    a_wake_raise: assert property (
        (|(q.status & q.wen)) |=> wake_o)
        else $error("wake not raised");
    a_wake_level: assert property (
        ((q.status & q.wen) == '0) |=> !wake_o)
        else $error("wake without enabled event");
endmodule

// ==== sim/rtc_calendar_alarm_stopwatch_bench.sv ====
/*
 * self-checking bench of the real-time clock: carries, alarms, stopwatch,
 * sticky events, irq and wake, driven over classic wishbone.
 * assumes rtc_top with a short prescaler and the assertions held inside it.
 */
`timescale 1ns/1ns
`include "rtc_cfg.svh"
module rtc_calendar_alarm_stopwatch_bench
    import rtc_pkg::*;
;
    // ------------------------------------------------------------------------
    // clock, reset and stimulus nets
    // ------------------------------------------------------------------------
    localparam int DIV = 4; // short prescaler keeps one second at 32 clocks
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic xtal_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_o;
    logic wake_o;
    int failures = 0;
    int n_compared = 0;

    rtc_top #(.PRESCALE_DIV(DIV), .SW_W(32)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .xtal_i(xtal_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .wake_o(wake_o)
    );

    // 25 MHz system clock
    always #20 clk_i = ~clk_i;

    // crystal stand-in: eight clocks a period, well below clk_i/4
    always begin
        repeat (4) @(posedge clk_i);
        xtal_i <= ~xtal_i;
    end

    // ------------------------------------------------------------------------
    // bus, compare and closing tasks
    // ------------------------------------------------------------------------
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; ack is read before the edge's own updates land
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] sel, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] sel = 4'hF);
        logic [31:0] q;
        wb_xfer(1'b1, a, d, sel, q);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                          input logic [31:0] mask = 32'hFFFF_FFFF);
        logic [31:0] q;
        wb_xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
        chk(what, exp & mask, q & mask);
    endtask

    // clear all flags, then wait for the next second event plus settle time
    task automatic sync_tick();
        logic [31:0] q;
        int n;
        wr(`RTC_OFS_CLEAR, 32'h0000_007F);
        n = 0;
        do begin
            wb_xfer(1'b0, `RTC_OFS_STATUS, 32'h0000_0000, 4'hF, q);
            n++;
        end while (q[EV_SEC] !== 1'b1 && n < 100);
        chk("tick seen", 32'h1, {31'h0, q[EV_SEC]});
        repeat (4) @(posedge clk_i);
    endtask

    // ------------------------------------------------------------------------
    // expectation helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] tod(input int h, input int m, input int s);
        return {11'h000, 5'(h), 2'h0, 6'(m), 2'h0, 6'(s)};
    endfunction

    function automatic logic [31:0] wrap_bits(input int h, input int m, input int s);
        return {28'h0, h == 23 && m == 59 && s == 59, m == 59 && s == 59, s == 59, 1'b1};
    endfunction

    // one second forward from h:m:s on day d
    task automatic tick_case(input int h, input int m, input int s, input int d);
        int s2, m2, h2, d2;
        s2 = (s + 1) % 60;
        m2 = (s == 59) ? (m + 1) % 60 : m;
        h2 = (s == 59 && m == 59) ? (h + 1) % 24 : h;
        d2 = (s == 59 && m == 59 && h == 23) ? (d + 1) % 32768 : d;
        sync_tick();
        wr(`RTC_OFS_TIME, tod(h, m, s));
        wr(`RTC_OFS_DAY, 32'(d));
        sync_tick();
        rd_chk("time", `RTC_OFS_TIME, tod(h2, m2, s2));
        rd_chk("day", `RTC_OFS_DAY, 32'(d2));
        rd_chk("periodic", `RTC_OFS_STATUS, wrap_bits(h, m, s), 32'hF);
    endtask

    // time moves 5:06:07 to 5:06:08, where both alarms are set
    task automatic alarm_case(input logic [31:0] ctrl, input int aday, input int day,
                              input logic [31:0] exp);
        wr(`RTC_OFS_CTRL, ctrl);
        wr(`RTC_OFS_ALM2_DAY, 32'(aday));
        sync_tick();
        wr(`RTC_OFS_DAY, 32'(day));
        wr(`RTC_OFS_TIME, tod(5, 6, 7));
        sync_tick();
        rd_chk("alarm flags", `RTC_OFS_STATUS, exp, 32'h30);
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        void'($urandom(32'h0B1C));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("ctrl reset", `RTC_OFS_CTRL, 32'h0);
        rd_chk("time reset", `RTC_OFS_TIME, 32'h0);
        rd_chk("status reset", `RTC_OFS_STATUS, 32'h0);
        rd_chk("unmapped", 8'h40, 32'h0);
        chk("irq reset", 32'h0, {31'h0, irq_o});
        // no second event before the prescaler completes
        sync_tick();
        wr(`RTC_OFS_CLEAR, 32'h1); // drop the flag of the tick just seen
        repeat (16) @(posedge clk_i);
        rd_chk("early tick", `RTC_OFS_STATUS, 32'h0, 32'h1);
        // carries: corners first, then random times
        tick_case(23, 59, 59, 32767);
        tick_case(0, 59, 59, 7);
        tick_case(22, 0, 59, 100);
        for (int i = 0; i < 6; i++) begin
            tick_case($urandom_range(23), $urandom_range(59), $urandom_range(59),
                      $urandom_range(32767));
        end
        // alarms: disabled, time-only, day and time
        wr(`RTC_OFS_ALM1, tod(5, 6, 8));
        wr(`RTC_OFS_ALM2, tod(5, 6, 8));
        alarm_case(32'h0, 9, 9, 32'h00);
        alarm_case(32'h1, 3, 9, 32'h10);
        alarm_case(32'h2, 3, 9, 32'h00);
        alarm_case(32'h3, 9, 9, 32'h30);
        // stopwatch counts 2, 1, 0, then flags and stays at zero
        wr(`RTC_OFS_CTRL, 32'h4);
        sync_tick();
        wr(`RTC_OFS_SWATCH, 32'h2);
        for (int k = 0; k < 3; k++) begin
            sync_tick();
            rd_chk("swatch", `RTC_OFS_SWATCH, (k < 2) ? 32'(1 - k) : 32'h0);
            rd_chk("underflow", `RTC_OFS_STATUS, (k == 2) ? 32'h40 : 32'h0, 32'h40);
        end
        // disabling pauses the count
        wr(`RTC_OFS_SWATCH, 32'h5);
        wr(`RTC_OFS_CTRL, 32'h0);
        sync_tick();
        rd_chk("paused", `RTC_OFS_SWATCH, 32'h5);
        // irq follows enabled sticky flags; clear lanes and clear register
        sync_tick();
        wr(`RTC_OFS_IEN, 32'h1 << EV_SWATCH);
        repeat (3) @(negedge clk_i);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wr(`RTC_OFS_IEN, 32'h1 << EV_SEC);
        repeat (3) @(negedge clk_i);
        chk("irq on", 32'h1, {31'h0, irq_o});
        wr(`RTC_OFS_CLEAR, 32'h0000_007F, 4'h0);
        repeat (3) @(negedge clk_i);
        chk("irq sticky", 32'h1, {31'h0, irq_o});
        // fresh second, so no new tick lands before the clear is looked at
        sync_tick();
        wr(`RTC_OFS_CLEAR, 32'h1);
        repeat (3) @(negedge clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        rd_chk("clear reads 0", `RTC_OFS_CLEAR, 32'h0);
        // wake line after the next enabled second event
        wr(`RTC_OFS_WEN, 32'h1 << EV_SEC);
        chk("wake idle", 32'h0, {31'h0, wake_o});
        sync_tick();
        chk("wake on", 32'h1, {31'h0, wake_o});
        test_done();
    end

    // hang guard, far beyond the some 1200 cycles the run needs
    initial begin
        repeat (30000) @(posedge clk_i);
        failures++;
        test_done();
    end
endmodule
